//--- hw/ssr_buf.sv
// Two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module ssr_buf (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [7:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [7:0] out_data_o
);
   logic [7:0] mem [ssr_pkg::BUF_DEPTH];
   logic [7:0] next_mem [ssr_pkg::BUF_DEPTH];
   logic [0:0] wr_ptr;
   logic [0:0] rd_ptr;
   logic [1:0] count;
   logic [0:0] next_wr_ptr;
   logic [0:0] next_rd_ptr;
   logic [1:0] next_count;
   logic push;
   logic pop;

   // Pointer step, shared by both sides
   function automatic logic [0:0] ptr_step(input logic [0:0] ptr, input logic go);
      return go ? ptr + ssr_pkg::ONE_BIT : ptr;
   endfunction

   assign in_ready_o = (count != ssr_pkg::BUF_FULL);
   assign out_valid_o = (count != ssr_pkg::BUF_EMPTY);
   assign out_data_o = mem[rd_ptr];

   always_comb begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      next_wr_ptr = ptr_step(wr_ptr, push);
      next_rd_ptr = ptr_step(rd_ptr, pop);
      next_count = count + {1'h0, push} - {1'h0, pop};
      next_mem = mem;
      if (push) begin
         next_mem[wr_ptr] = in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ptr <= ssr_pkg::PTR_RST;
         rd_ptr <= ssr_pkg::PTR_RST;
         count <= ssr_pkg::COUNT_RST;
         for (int unsigned k = 0; k < ssr_pkg::BUF_DEPTH; k++) begin
            mem[k] <= ssr_pkg::WORD_RST;
         end
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         mem <= next_mem;
      end
   end
endmodule // ssr_buf
`default_nettype wire

//--- hw/ssr_pkg.sv
// Package of constants for the serial shift and store register
package ssr_pkg;
   localparam int unsigned STAGES = 8;
   localparam logic [7:0] CHAIN_RST = 8'h00;
   localparam logic [7:0] STORE_RST = 8'h00;
   localparam int unsigned BUF_DEPTH = 2;
   localparam logic [0:0] ONE_BIT = 1'h1;
   localparam int unsigned LAST = STAGES - 1;
   localparam logic CASC_RST = 1'h0;
   localparam logic SCK_IDLE = 1'h0;
   localparam logic [0:0] PTR_RST = 1'h0;
   localparam logic [1:0] COUNT_RST = 2'h0;
   localparam logic [1:0] BUF_EMPTY = 2'h0;
   localparam logic [1:0] BUF_FULL = 2'h2;
   localparam logic [7:0] WORD_RST = 8'h00;
endpackage

//--- hw/ssr_top.sv
// Serial shift and store register, 8 stages, with cascade outputs
`timescale 1ns/1ps
`default_nettype none
module ssr_top (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RSTN_I,
   // Serial link from host, taken as synchronous to CLK_I
   input wire logic SHIFT_CLOCK_IN_I,
   input wire logic SERIAL_DATA_I,
   input wire logic TRANSFER_STROBE_I,
   input wire logic OUTPUT_ENABLE_I,
   // Parallel outputs, three-state
   output logic [7:0] PARALLEL_OUT_O,
   output logic [7:0] PARALLEL_OUT_OE_N_O,
   // Cascade outputs
   output logic CASCADE_OUT_RISING_O,
   output logic CASCADE_OUT_FALLING_O,
   // Word stream of transferred words
   output logic WORD_VALID_O,
   input wire logic WORD_READY_I,
   output logic [7:0] WORD_DATA_O,
   output logic WORD_STALL_O
);
   // ------------------------------------------------------------
   // Timing at the ports
   // ------------------------------------------------------------
   // The shift clock is a level sampled on CLK_I; the CLK_I edge that first
   // sees a new level acts on it, and the outputs show the result after it.
   // Each shift clock level must stand for at least one CLK_I cycle, so at
   // most one bit enters every two CLK_I cycles.
   // The word stream cannot stall the host: a full buffer drops the word
   // from the stream, while the storage register still takes it.

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   // A sample at level lvl after a sample at the other level marks an edge
   function automatic logic edge_to(input logic cur, input logic prev, input logic lvl);
      logic at_lvl;
      logic was_other;
      at_lvl = (cur == lvl);
      was_other = (prev != lvl);
      return at_lvl && was_other;
   endfunction

   // Every stage takes the bit of the stage below, the serial bit enters stage one
   function automatic logic [7:0] shift_once(input logic [7:0] cur, input logic din);
      logic [7:0] res;
      res[0] = din;
      for (int unsigned k = 1; k < ssr_pkg::STAGES; k++) begin
         res[k] = cur[k-1];
      end
      return res;
   endfunction

   // Active-low enable for every parallel pin, low while the pins are driven
   function automatic logic [7:0] enable_mask(input logic oe);
      logic [7:0] res;
      for (int unsigned k = 0; k < ssr_pkg::STAGES; k++) begin
         res[k] = !oe;
      end
      return res;
   endfunction

   // Bit of the last stage, fed to both cascade paths
   function automatic logic last_bit(input logic [7:0] cur);
      return cur[ssr_pkg::LAST];
   endfunction

   // ------------------------------------------------------------
   // Edge detection of the shift clock
   // ------------------------------------------------------------
   // The last sample resets to the idle level, so reset brings no false edge
   logic clk_prev;
   logic next_clk_prev;
   logic rise;
   logic fall;

   always_comb begin
      rise = edge_to(SHIFT_CLOCK_IN_I, clk_prev, 1'h1);
      fall = edge_to(SHIFT_CLOCK_IN_I, clk_prev, 1'h0);
      next_clk_prev = SHIFT_CLOCK_IN_I;
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         clk_prev <= ssr_pkg::SCK_IDLE;
      end else begin
         clk_prev <= next_clk_prev;
      end
   end

   // ------------------------------------------------------------
   // Shift chain
   // ------------------------------------------------------------
   // Moves on every rise, whatever strobe and enable do; stage seven feeds stage eight
   logic [7:0] chain;
   logic [7:0] next_chain;

   always_comb begin
      next_chain = chain;
      if (rise) begin
         next_chain = shift_once(chain, SERIAL_DATA_I);
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         chain <= ssr_pkg::CHAIN_RST;
      end else begin
         chain <= next_chain;
      end
   end

   // ------------------------------------------------------------
   // Storage register
   // ------------------------------------------------------------
   // Takes the shifted chain in the same cycle, so a strobed rise shows at once
   logic [7:0] store;
   logic [7:0] next_store;

   always_comb begin
      next_store = store;
      if (TRANSFER_STROBE_I) begin
         next_store = next_chain;
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         store <= ssr_pkg::STORE_RST;
      end else begin
         store <= next_store;
      end
   end

   // ------------------------------------------------------------
   // Falling-edge cascade stage
   // ------------------------------------------------------------
   // Half a shift period behind the last stage, for a follower with a slow clock
   logic casc_fall;
   logic next_casc_fall;

   always_comb begin
      next_casc_fall = casc_fall;
      if (fall) begin
         next_casc_fall = last_bit(chain);
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         casc_fall <= ssr_pkg::CASC_RST;
      end else begin
         casc_fall <= next_casc_fall;
      end
   end

   // ------------------------------------------------------------
   // Word stream
   // ------------------------------------------------------------
   // One word per strobed rise while the buffer has room, carrying the new storage register value
   logic push_word;
   logic buf_ready;

   always_comb begin
      push_word = rise && TRANSFER_STROBE_I;
   end

   ssr_buf u_buf (
      .clk_i(CLK_I),
      .rstn_i(RSTN_I),
      .in_valid_i(push_word),
      .in_ready_o(buf_ready),
      .in_data_i(next_store),
      .out_valid_o(WORD_VALID_O),
      .out_ready_i(WORD_READY_I),
      .out_data_o(WORD_DATA_O)
   );

   // ------------------------------------------------------------
   // Stall output
   // ------------------------------------------------------------
   // High while the buffer holds two words
   always_comb begin
      WORD_STALL_O = !buf_ready;
   end

   // ------------------------------------------------------------
   // Parallel outputs
   // ------------------------------------------------------------
   // Releasing the pins never touches the storage register
   always_comb begin
      PARALLEL_OUT_O = store;
      PARALLEL_OUT_OE_N_O = enable_mask(OUTPUT_ENABLE_I);
   end

   // ------------------------------------------------------------
   // Cascade outputs
   // ------------------------------------------------------------
   // The rising output is the last stage itself
   always_comb begin
      CASCADE_OUT_RISING_O = last_bit(chain);
      CASCADE_OUT_FALLING_O = casc_fall;
   end

endmodule // ssr_top
`default_nettype wire

//--- tb/ssr_host.sv
// Host model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module ssr_host (
   // Clock
   input wire logic clk_i,
   // Serial link
   output logic sck_o,
   output logic sd_o,
   output logic strobe_o
);
   initial {sck_o, sd_o, strobe_o} = 3'h0;
   task automatic st(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Clock stands low outside frames, idle data is the inverse of the last bit
   task automatic send(input logic [7:0] w, input int n, input logic s);
      for (int i = 7; i >= 0; i--) begin
         sd_o = w[i];
         strobe_o = s;
         st(n);
         sck_o = 1'h1;
         st(n);
         sck_o = 1'h0;
      end
      sd_o = ~sd_o;
   endtask
   task automatic pulse;
      strobe_o = 1'h1;
      st(1);
      strobe_o = 1'h0;
   endtask
endmodule // ssr_host
`default_nettype wire

//--- tb/ssr_properties.sv
// Checker of the shift and store register ports
`timescale 1ns/1ps
`default_nettype none
module ssr_chk (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RSTN_I,
   // Serial link
   input wire logic SHIFT_CLOCK_IN_I,
   input wire logic SERIAL_DATA_I,
   input wire logic TRANSFER_STROBE_I,
   input wire logic OUTPUT_ENABLE_I,
   // Outputs watched
   input wire logic [7:0] PARALLEL_OUT_O,
   input wire logic [7:0] PARALLEL_OUT_OE_N_O,
   input wire logic CASCADE_OUT_RISING_O,
   input wire logic CASCADE_OUT_FALLING_O
);
   logic q;
   wire r = SHIFT_CLOCK_IN_I & !q;
   wire f = !SHIFT_CLOCK_IN_I & q;
   wire s = TRANSFER_STROBE_I;
   wire [7:0] po = PARALLEL_OUT_O;
   wire cr = CASCADE_OUT_RISING_O;
   wire cf = CASCADE_OUT_FALLING_O;
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) q <= 1'h0;
      else q <= SHIFT_CLOCK_IN_I;
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   // Rising shift edge with the store tracking the chain
   sequence s_tr; r && s && $past(s); endsequence
   property p_load; r && s |=> po[0] == $past(SERIAL_DATA_I); endproperty
   a_load: assert property (p_load) else $error("load");
   property p_fol; s_tr |=> po[7:1] == $past(po[6:0]); endproperty
   a_fol: assert property (p_fol) else $error("follow");
   property p_hold; !s |=> $stable(po); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_oe; PARALLEL_OUT_OE_N_O == {8{!OUTPUT_ENABLE_I}}; endproperty
   a_oe: assert property (p_oe) else $error("enable");
   property p_casc; s_tr |=> cr == $past(po[6]); endproperty
   a_casc: assert property (p_casc) else $error("cascade");
   property p_rst; !r |=> $stable(cr); endproperty
   a_rst: assert property (p_rst) else $error("rise out");
   property p_fall; f |=> cf == $past(cr); endproperty
   a_fall: assert property (p_fall) else $error("fall");
   property p_fst; !f |=> $stable(cf); endproperty
   a_fst: assert property (p_fst) else $error("fall out");
endmodule // ssr_chk
bind ssr_top ssr_chk i_ssr_chk (.*);
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench of the shift and store register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'h0, rstn = 1'h0, oe = 1'h1, rdy = 1'h0;
   wire sck, sd, strobe, cr, cf, wv, ws;
   wire [7:0] po, oen, wd;
   int err_count = 0, n_compared = 0;
   initial forever #12.5 clk = ~clk;
   ssr_host i_ssr_host (.clk_i(clk), .sck_o(sck), .sd_o(sd), .strobe_o(strobe));
   ssr_top i_ssr_top (.CLK_I(clk), .RSTN_I(rstn), .SHIFT_CLOCK_IN_I(sck), .SERIAL_DATA_I(sd),
      .TRANSFER_STROBE_I(strobe), .OUTPUT_ENABLE_I(oe), .PARALLEL_OUT_O(po), .PARALLEL_OUT_OE_N_O(oen),
      .CASCADE_OUT_RISING_O(cr), .CASCADE_OUT_FALLING_O(cf), .WORD_VALID_O(wv), .WORD_READY_I(rdy),
      .WORD_DATA_O(wd), .WORD_STALL_O(ws));
   task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic st(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic final_report;
      $display("Errors %0d of %0d checks", err_count, n_compared);
      if (err_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Strobed frame into a stalled word stream, then drained
   task automatic t_stream;
      i_ssr_host.send(8'hA5, 1, 1'h1);
      st(2);
      chk("par", po, 8'hA5);
      chk("oen", oen, 8'h00);
      chk("casc", {6'h00, cf, cr}, 8'h03);
      chk("stall", {6'h00, wv, ws}, 8'h03);
      chk("word", wd, 8'h01);
      rdy = 1'h1;
      st(1);
      chk("word", wd, 8'h02);
      st(1);
      chk("valid", {7'h00, wv}, 8'h00);
   endtask
   // Slow frame with strobe low and outputs released
   task automatic t_latch;
      oe = 1'h0;
      i_ssr_host.send(8'h3C, 3, 1'h0);
      st(2);
      chk("hold", po, 8'hA5);
      chk("oen", oen, 8'hFF);
      i_ssr_host.pulse;
      chk("par", po, 8'h3C);
      chk("casc", {6'h00, cf, cr}, 8'h00);
   endtask
   // Mid-run reset after a frame that sets both cascade outputs
   task automatic t_reset;
      i_ssr_host.send(8'hC3, 1, 1'h0);
      st(2);
      chk("casc", {6'h00, cf, cr}, 8'h03);
      rstn = 1'h0;
      st(2);
      rstn = 1'h1;
      st(1);
      chk("rst par", po, ssr_pkg::STORE_RST);
      chk("rst casc", {6'h00, cf, cr}, {6'h00, ssr_pkg::CASC_RST, ssr_pkg::CHAIN_RST[ssr_pkg::LAST]});
      chk("rst word", {7'h00, wv}, 8'h00);
   endtask
   initial begin
      st(20);
      rstn = 1'h1;
      st(1);
      t_stream;
      t_latch;
      t_reset;
      final_report;
   end
   initial begin
      #100us;
      err_count++;
      final_report;
   end
endmodule // tb_top
`default_nettype wire
